// ==== core/ssf_top.sv ====
// service and first status register group of the transceiver
//
// Contract
// - calibration bit 7 enables temperature-driven automatic calibration
// - writing one to bit 6 in standby starts calibration; not stored
// - bit 5 reads one while calibration runs; resets to zero
// - bit 3 flags temperature change beyond threshold since last calibration
// - bits 2-1 select 5, 10, 15 or 20 degree threshold; reset 01
// - bit 0 zero monitors outside sleep and standby; one stops it
// - temperature register presents measured value, minus one degree per lsb
// - low-battery bit 3 enables the detector; resets to zero
// - low-battery bits 2-0 select one of eight thresholds; reset 2
// - flag bit 7 sets on mode ready, clears on mode change
// - flag bit 6 sets when receive settles, clears leaving receive
// - flag bit 5 sets after transmit ramp, clears leaving transmit
// - flag bit 4 shows lock in synth, receive or transmit modes
// - flag bit 3 sets on level above limit; clears leaving or write-one
// - flag bit 2 sets on timeout; clears leaving receive or fifo emptied
// - flag bit 1 sets on preamble found; clears on write-one
// - flag bit 0 sets on sync match; clears leaving or fifo emptied
`timescale 1ns/1ps
module ssf_top #(
  parameter int TEMP_PERIOD = ssf_pkg::TEMP_PERIOD_CYC,
  parameter int CAL_CYCLES = ssf_pkg::CAL_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // host register port
  input wire ssf_pkg::ssf_bus_req_t bus_req,
  output logic [7:0] rdata,
  // radio datapath
  input wire ssf_pkg::ssf_radio_t radio,
  input wire logic [7:0] temp_code,
  // analog controls
  output logic cal_run,
  output logic temp_sense_on,
  output logic battery_detector_enable,
  output logic [2:0] battery_threshold_select,
  // interrupt
  output logic irq
);
  import ssf_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic wr_at(input ssf_bus_req_t r,
                                 input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  function automatic logic rd_at(input ssf_bus_req_t r,
                                 input logic [7:0] a);
    return r.rd && (r.addr == a);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic auto_cal_enable_reg, auto_cal_enable_next;
  logic [1:0] temperature_delta_select_reg, temperature_delta_select_next;
  logic thermal_monitor_disable_reg, thermal_monitor_disable_next;
  logic bat_en_reg, bat_en_next;
  logic [2:0] bat_sel_reg, bat_sel_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] stat_reg, stat_next, mask_reg, mask_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic cal_run_reg, sense_reg, sense_next;
  logic [2:0] mode_prev_reg;
  logic [7:0] flg_w1c, stat_w1c;
  logic in_rx, in_tx, mode_change, synth_mode;
  logic cal_trigger, cal_start, cal_in_progress, cal_done;
  logic temperature_moved_flag, mon_active;
  logic [7:0] measured_temperature;

  // ----------------------------------------------------------------
  // calibration and temperature monitor
  // ----------------------------------------------------------------
  // trigger bit is only a strobe, so it never reaches storage
  assign cal_trigger = wr_at(bus_req, ADDR_IMAGE_CAL)
                       && bus_req.wdata[CAL_TRIG_BIT]
                       && (radio.mode == MODE_STBY);
  // automatic recalibration after a temperature excursion; the moved flag
  // only drops the cycle after done, so done must block a second run
  assign cal_start = cal_trigger
                     || (auto_cal_enable_reg && temperature_moved_flag
                         && !cal_in_progress && !cal_done);
  assign mon_active = !thermal_monitor_disable_reg
                      && (radio.mode != MODE_SLEEP)
                      && (radio.mode != MODE_STBY);

  ssf_cal_seq #(
    .CYCLES(CAL_CYCLES)
  ) u_cal (
    .clk(clk),
    .rst_b(rst_b),
    .start(cal_start),
    .running(cal_in_progress),
    .done(cal_done)
  );

  ssf_temp_mon #(
    .PERIOD(TEMP_PERIOD)
  ) u_mon (
    .clk(clk),
    .rst_b(rst_b),
    .active(mon_active),
    .delta_sel(temperature_delta_select_reg),
    .cal_done(cal_done),
    .temp_code(temp_code),
    .temp_value(measured_temperature),
    .moved(temperature_moved_flag)
  );

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // only defined fields are stored; other write bits are dropped
  always_comb begin
    auto_cal_enable_next = auto_cal_enable_reg;
    temperature_delta_select_next = temperature_delta_select_reg;
    thermal_monitor_disable_next = thermal_monitor_disable_reg;
    bat_en_next = bat_en_reg;
    bat_sel_next = bat_sel_reg;
    mask_next = mask_reg;
    if (wr_at(bus_req, ADDR_IMAGE_CAL)) begin
      auto_cal_enable_next = bus_req.wdata[CAL_AUTO_BIT];
      temperature_delta_select_next =
        bus_req.wdata[CAL_DSEL_LSB +: 2];
      thermal_monitor_disable_next =
        bus_req.wdata[CAL_MONOFF_BIT];
    end
    if (wr_at(bus_req, ADDR_LOW_BAT)) begin
      bat_en_next = bus_req.wdata[BAT_EN_BIT];
      bat_sel_next = bus_req.wdata[2:0];
    end
    if (wr_at(bus_req, ADDR_IRQ_MASK)) begin
      mask_next = bus_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // first flag register
  // ----------------------------------------------------------------
  assign in_rx = (radio.mode == MODE_RX);
  assign in_tx = (radio.mode == MODE_TX);
  assign mode_change = (radio.mode != mode_prev_reg);
  assign synth_mode = (radio.mode == MODE_FSTX)
                      || (radio.mode == MODE_FSRX) || in_rx || in_tx;
  // writing zero leaves a flag alone; only write-one bits clear
  assign flg_w1c = wr_at(bus_req, ADDR_FLAGS1)
                   ? (bus_req.wdata & FLG_W1C_MASK) : 8'h00;

  // set terms are ored after their clears, so the event survives, except rx ready, tx ready and level, where leaving the mode wins
  always_comb begin
    flags_next = 8'h00;
    flags_next[FLG_MODE_RDY] = radio.mode_ready_evt
      || (flags_reg[FLG_MODE_RDY] && !mode_change);
    flags_next[FLG_RX_RDY] = in_rx
      && (radio.rx_ready_evt || flags_reg[FLG_RX_RDY]);
    flags_next[FLG_TX_RDY] = in_tx
      && (radio.tx_ramp_done || flags_reg[FLG_TX_RDY]);
    flags_next[FLG_LOCK] = synth_mode && radio.pll_locked;
    flags_next[FLG_LEVEL] = in_rx
      && ((radio.signal_level_reading > radio.signal_level_limit)
          || (flags_reg[FLG_LEVEL] && !flg_w1c[FLG_LEVEL]));
    flags_next[FLG_TIMEOUT] = radio.timeout_evt
      || (flags_reg[FLG_TIMEOUT] && in_rx
          && !radio.fifo_emptied);
    flags_next[FLG_PREAMBLE] = radio.preamble_evt
      || (flags_reg[FLG_PREAMBLE]
          && !flg_w1c[FLG_PREAMBLE]);
    flags_next[FLG_SYNC] = radio.sync_evt
      || (flags_reg[FLG_SYNC] && in_rx
          && !radio.fifo_emptied);
  end

  // ----------------------------------------------------------------
  // interrupt status, mask and output
  // ----------------------------------------------------------------
  // status records rising edges of the flags, cleared by writing one
  assign stat_w1c = wr_at(bus_req, ADDR_IRQ_STAT)
                    ? bus_req.wdata : 8'h00;
  always_comb begin
    stat_next = (stat_reg & ~stat_w1c)
                | (flags_next & ~flags_reg);
    irq_next = |(stat_next & mask_next);
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // data stand for exactly one cycle after the read strobe
  always_comb begin
    rdata_next = 8'h00;
    if (rd_at(bus_req, ADDR_IMAGE_CAL)) begin
      rdata_next[CAL_AUTO_BIT] = auto_cal_enable_reg;
      rdata_next[CAL_RUN_BIT] = cal_in_progress;
      rdata_next[CAL_MOVED_BIT] = temperature_moved_flag;
      rdata_next[CAL_DSEL_LSB +: 2] = temperature_delta_select_reg;
      rdata_next[CAL_MONOFF_BIT] = thermal_monitor_disable_reg;
    end else if (rd_at(bus_req, ADDR_TEMP)) begin
      rdata_next = measured_temperature;
    end else if (rd_at(bus_req, ADDR_LOW_BAT)) begin
      rdata_next = {4'h0, bat_en_reg, bat_sel_reg};
    end else if (rd_at(bus_req, ADDR_FLAGS1)) begin
      rdata_next = flags_reg;
    end else if (rd_at(bus_req, ADDR_IRQ_STAT)) begin
      rdata_next = stat_reg;
    end else if (rd_at(bus_req, ADDR_IRQ_MASK)) begin
      rdata_next = mask_reg;
    end
    sense_next = mon_active;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_cal_enable_reg <= 1'b0;
      temperature_delta_select_reg <= DSEL_RST;
      thermal_monitor_disable_reg <= 1'b0;
      bat_en_reg <= 1'b0;
      bat_sel_reg <= BAT_SEL_RST;
      flags_reg <= 8'h00;
      stat_reg <= 8'h00;
      mask_reg <= 8'h00;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      cal_run_reg <= 1'b0;
      sense_reg <= 1'b0;
      mode_prev_reg <= MODE_SLEEP;
    end else begin
      auto_cal_enable_reg <= auto_cal_enable_next;
      temperature_delta_select_reg <= temperature_delta_select_next;
      thermal_monitor_disable_reg <= thermal_monitor_disable_next;
      bat_en_reg <= bat_en_next;
      bat_sel_reg <= bat_sel_next;
      flags_reg <= flags_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      cal_run_reg <= cal_in_progress;
      sense_reg <= sense_next;
      mode_prev_reg <= radio.mode;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign cal_run = cal_run_reg;
  assign temp_sense_on = sense_reg;
  assign battery_detector_enable = bat_en_reg;
  assign battery_threshold_select = bat_sel_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_cal_auto_wr: assert property (
    wr_at(bus_req, ADDR_IMAGE_CAL)
    |=> auto_cal_enable_reg == $past(bus_req.wdata[CAL_AUTO_BIT]))
    else $error("auto calibration enable not written");

  chk_cal_trig_start: assert property (
    cal_trigger && !cal_in_progress |=> cal_in_progress ##1 cal_run)
    else $error("calibration trigger did not start a run");

  chk_cal_busy_read: assert property (
    rd_at(bus_req, ADDR_IMAGE_CAL)
    |=> rdata[CAL_RUN_BIT] == $past(cal_in_progress))
    else $error("calibration busy bit misread");

  chk_mon_off_gate: assert property (
    thermal_monitor_disable_reg |=> !temp_sense_on)
    else $error("temperature monitor ran while disabled");

  chk_bat_write: assert property (
    wr_at(bus_req, ADDR_LOW_BAT)
    |=> {battery_detector_enable, battery_threshold_select}
        == $past(bus_req.wdata[3:0]))
    else $error("low battery control not written");

  chk_mode_rdy_clr: assert property (
    mode_change && !radio.mode_ready_evt
    |=> !flags_reg[FLG_MODE_RDY])
    else $error("mode ready kept over a mode change");

  chk_rx_rdy_leave: assert property (
    !in_rx && !in_tx |=> !flags_reg[FLG_RX_RDY] && !flags_reg[FLG_TX_RDY])
    else $error("ready flag kept outside its mode");

  chk_lock_follow: assert property (
    ##1 flags_reg[FLG_LOCK]
        == $past(synth_mode && radio.pll_locked))
    else $error("lock flag does not follow the pll");

  chk_level_set_wins: assert property (
    in_rx && radio.signal_level_reading > radio.signal_level_limit
    |=> flags_reg[FLG_LEVEL])
    else $error("level event lost");

  chk_preamble_w1c: assert property (
    flags_reg[FLG_PREAMBLE] && !radio.preamble_evt
    |=> flags_reg[FLG_PREAMBLE] == !$past(flg_w1c[FLG_PREAMBLE]))
    else $error("preamble flag clear wrong");

  chk_fifo_clear: assert property (
    radio.fifo_emptied && !radio.timeout_evt && !radio.sync_evt
    |=> !flags_reg[FLG_TIMEOUT] && !flags_reg[FLG_SYNC])
    else $error("fifo emptied did not clear flags");

  chk_cal_single_run: assert property (
    cal_done && !cal_trigger |=> !cal_in_progress)
    else $error("calibration restarted without a request");

  chk_tx_rdy_set: assert property (
    in_tx && radio.tx_ramp_done |=> flags_reg[FLG_TX_RDY])
    else $error("transmit ready event lost");

  chk_temp_read: assert property (
    rd_at(bus_req, ADDR_TEMP)
    |=> rdata == $past(measured_temperature))
    else $error("temperature register misread");

  chk_unused_zero: assert property (
    rd_at(bus_req, ADDR_LOW_BAT) |=> rdata[7:4] == 4'h0)
    else $error("unused low battery bits not zero");

  chk_irq_level: assert property (
    ##1 irq == |(stat_reg & mask_reg))
    else $error("interrupt output out of step");

  cov_cal_run: cover property (cal_trigger ##1 cal_in_progress);
  cov_level_rx: cover property (in_rx ##1 flags_reg[FLG_LEVEL]);
  cov_preamble_clear: cover property (
    flags_reg[FLG_PREAMBLE] ##1 !flags_reg[FLG_PREAMBLE]);
  cov_irq: cover property (irq);
endmodule // ssf_top

// ==== core/ssf_pkg.sv ====
// package: register map, fields, modes, timing and carriers of the flags
package ssf_pkg;
  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;

  // ----------------------------------------------------------------
  // register offsets on the host register port
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IMAGE_CAL = 8'h3B;
  localparam logic [7:0] ADDR_TEMP = 8'h3C;
  localparam logic [7:0] ADDR_LOW_BAT = 8'h3D;
  localparam logic [7:0] ADDR_FLAGS1 = 8'h3E;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h50;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h51;

  // image_calibration_control fields and reset values
  localparam int CAL_AUTO_BIT = 7;
  localparam int CAL_TRIG_BIT = 6;
  localparam int CAL_RUN_BIT = 5;
  localparam int CAL_MOVED_BIT = 3;
  localparam int CAL_DSEL_LSB = 1;
  localparam int CAL_MONOFF_BIT = 0;
  localparam logic [1:0] DSEL_RST = 2'h1;

  // low_battery_control fields and reset values
  localparam int BAT_EN_BIT = 3;
  localparam logic [2:0] BAT_SEL_RST = 3'h2;

  // interrupt_flags_first bit positions
  localparam int FLG_MODE_RDY = 7;
  localparam int FLG_RX_RDY = 6;
  localparam int FLG_TX_RDY = 5;
  localparam int FLG_LOCK = 4;
  localparam int FLG_LEVEL = 3;
  localparam int FLG_TIMEOUT = 2;
  localparam int FLG_PREAMBLE = 1;
  localparam int FLG_SYNC = 0;
  localparam logic [7:0] FLG_W1C_MASK = 8'h0A;

  // operating mode codes
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STBY = 3'h1;
  localparam logic [2:0] MODE_FSTX = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_FSRX = 3'h4;
  localparam logic [2:0] MODE_RX = 3'h5;

  // ----------------------------------------------------------------
  // temperature and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] DELTA_STEP_DEG = 8'h05;
  localparam int TEMP_PERIOD_US = 100;
  localparam int TEMP_PERIOD_CYC = TEMP_PERIOD_US * CLK_MHZ;
  localparam int CAL_TIME_US = 10;
  localparam int CAL_CYC = CAL_TIME_US * CLK_MHZ;

  // host register request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ssf_bus_req_t;

  // radio events and levels from the datapath
  typedef struct packed {
    logic [2:0] mode;
    logic mode_ready_evt;
    logic rx_ready_evt;
    logic tx_ramp_done;
    logic pll_locked;
    logic [7:0] signal_level_reading;
    logic [7:0] signal_level_limit;
    logic timeout_evt;
    logic fifo_emptied;
    logic preamble_evt;
    logic sync_evt;
  } ssf_radio_t;
endpackage

// ==== core/ssf_cal_seq.sv ====
// calibration sequencer: runs a fixed-length calibration after a start
`timescale 1ns/1ps
module ssf_cal_seq #(
  parameter int CYCLES = ssf_pkg::CAL_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic start,
  // status
  output logic running,
  output logic done
);
  import ssf_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);
  typedef enum logic {CAL_IDLE, CAL_RUN} ssf_cal_state_t;
  ssf_cal_state_t state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic done_reg, done_next;

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  // a start while running is ignored; one run covers both requests
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    case (state_reg)
      CAL_IDLE: begin
        if (start) begin
          state_next = CAL_RUN;
          cnt_next = '0;
        end
      end
      CAL_RUN: begin
        if (cnt_reg == CW'(CYCLES - 1)) begin
          state_next = CAL_IDLE;
          done_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      default: state_next = CAL_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= CAL_IDLE;
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign running = (state_reg == CAL_RUN);
  assign done = done_reg;
endmodule // ssf_cal_seq

// ==== core/ssf_temp_mon.sv ====
// temperature monitor: periodic sampling and change detection
`timescale 1ns/1ps
module ssf_temp_mon #(
  parameter int PERIOD = ssf_pkg::TEMP_PERIOD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic active,
  input wire logic [1:0] delta_sel,
  input wire logic cal_done,
  // sensor
  input wire logic [7:0] temp_code,
  // results
  output logic [7:0] temp_value,
  output logic moved
);
  import ssf_pkg::*;
  localparam int PW = $clog2(PERIOD + 1);
  logic [PW-1:0] div_reg, div_next;
  logic [7:0] value_reg, value_next, ref_reg, ref_next;
  logic ref_ok_reg, ref_ok_next, moved_reg, moved_next;
  logic tick;
  logic [7:0] diff, limit;

  // ----------------------------------------------------------------
  // sample divider and change compare
  // ----------------------------------------------------------------
  // divider is held at zero while idle so a sample never comes early
  always_comb begin
    tick = active && (div_reg == PW'(PERIOD - 1));
    div_next = (!active || tick) ? '0 : div_reg + 1'b1;
    diff = (temp_code > ref_reg) ? temp_code - ref_reg
                                 : ref_reg - temp_code;
    limit = 8'(DELTA_STEP_DEG * ({6'h00, delta_sel} + 8'h01));
    value_next = tick ? temp_code : value_reg;
    ref_next = ref_reg;
    ref_ok_next = ref_ok_reg;
    moved_next = moved_reg;
    // a finished calibration sets the new reference
    if (cal_done) begin
      ref_next = value_reg;
      ref_ok_next = 1'b1;
      moved_next = 1'b0;
    end
    // a new excursion wins over the calibration clear
    if (tick && ref_ok_reg && diff > limit) begin
      moved_next = 1'b1;
    end
  end

  // monitor registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= '0;
      value_reg <= 8'h00;
      ref_reg <= 8'h00;
      ref_ok_reg <= 1'b0;
      moved_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      value_reg <= value_next;
      ref_reg <= ref_next;
      ref_ok_reg <= ref_ok_next;
      moved_reg <= moved_next;
    end
  end

  assign temp_value = value_reg;
  assign moved = moved_reg;
endmodule // ssf_temp_mon

// ==== verification/ssf_top_tb.sv ====
// self-checking bench for the service and first status register group
`timescale 1ns/1ps
module ssf_top_tb;
  import ssf_pkg::*;
  // ----------------------------------------------------------------
  // clock, stimulus signals and design
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  ssf_bus_req_t bus_req = '0;
  ssf_radio_t radio = '0;
  logic [7:0] temp_code = 8'h40;
  logic [7:0] rdata;
  logic cal_run;
  logic temp_sense_on;
  logic battery_detector_enable;
  logic [2:0] battery_threshold_select;
  logic irq;
  logic [7:0] exp_q[$];
  logic [7:0] d;
  logic [7:0] pins;
  logic rd_q = 1'b0;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  // short counts keep the run brief; expectations use the same values
  ssf_top #(.TEMP_PERIOD(8), .CAL_CYCLES(4)) ssf_top_inst (
    .clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata),
    .radio(radio), .temp_code(temp_code), .cal_run(cal_run),
    .temp_sense_on(temp_sense_on),
    .battery_detector_enable(battery_detector_enable),
    .battery_threshold_select(battery_threshold_select), .irq(irq));

  // outputs packed for pin checks: cal run, sense, irq, spare, battery
  assign pins = {cal_run, temp_sense_on, irq, 1'b0,
                 battery_detector_enable, battery_threshold_select};
  localparam logic [7:0] PIN_CAL = 8'h80;
  localparam logic [7:0] PIN_SENSE = 8'h40;
  localparam logic [7:0] PIN_IRQ = 8'h20;
  localparam logic [7:0] PIN_BAT = 8'h0F;

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  // pins are looked at mid-cycle where they have settled; the task then
  // returns on a rising edge so the next drive lands on the edge again
  task automatic chk_pin(input logic [7:0] sel, input logic [7:0] exp);
    @(negedge clk);
    checks_done++;
    if ((pins & sel) !== exp) begin
      err_total++;
      $display("[ERR] %0t pin %h expected %h", $time, pins & sel, exp);
    end
    @(posedge clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // read data stand only in the cycle after the strobe: compare mid-cycle
  always @(posedge clk) rd_q <= bus_req.rd;
  always @(negedge clk) begin
    if (rd_q) chk_rd(rdata, exp_q.pop_front());
  end

  // hang guard, the tests need well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // bus and event drivers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic pre = 1'b0);
    bus_req.addr <= a;
    bus_req.wdata <= v;
    bus_req.wr <= 1'b1;
    radio.preamble_evt <= pre;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    radio.preamble_evt <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(posedge clk);
  endtask

  // order: mode ready, rx ready, tx ramp, timeout, fifo empty, preamble, sync
  task automatic pulse(input logic [6:0] v);
    {radio.mode_ready_evt, radio.rx_ready_evt, radio.tx_ramp_done,
     radio.timeout_evt, radio.fifo_emptied, radio.preamble_evt,
     radio.sync_evt} <= v;
    @(posedge clk);
    {radio.mode_ready_evt, radio.rx_ready_evt, radio.tx_ramp_done,
     radio.timeout_evt, radio.fifo_emptied, radio.preamble_evt,
     radio.sync_evt} <= 7'h00;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(9814));
    radio.mode <= MODE_STBY;
    radio.pll_locked <= 1'b1;
    radio.signal_level_reading <= 8'h80;
    radio.signal_level_limit <= 8'h10;
    tick(20);
    rst_b <= 1'b1;
    tick(1);
    rd(ADDR_IMAGE_CAL, 8'h02);
    rd(ADDR_LOW_BAT, 8'h02);
    rd(ADDR_FLAGS1, 8'h00);
    rd(ADDR_IRQ_STAT, 8'h00);
    chk_pin(PIN_BAT, 8'h02);
    $display("test reset done");
    // random settings, upper nibble must be dropped
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(ADDR_LOW_BAT, d);
      chk_pin(PIN_BAT, {4'h0, d[3:0]});
      rd(ADDR_LOW_BAT, {4'h0, d[3:0]});
    end
    wr(8'h7F, 8'hFF);
    rd(8'h7F, 8'h00);
    $display("test battery done");
    // monitor runs outside standby; the reading held when calibration finishes becomes the reference
    radio.mode <= MODE_FSRX;
    tick(20);
    rd(ADDR_TEMP, 8'h40);
    chk_pin(PIN_SENSE, 8'h40);
    radio.mode <= MODE_STBY;
    tick(2);
    wr(ADDR_IMAGE_CAL, 8'h40);
    rd(ADDR_IMAGE_CAL, 8'h20);
    chk_pin(PIN_CAL, 8'h80);
    tick(8);
    rd(ADDR_IMAGE_CAL, 8'h00);
    chk_pin(PIN_CAL, 8'h00);
    radio.mode <= MODE_FSRX;
    temp_code <= 8'h45;
    tick(20);
    rd(ADDR_IMAGE_CAL, 8'h00);
    temp_code <= 8'h47;
    tick(20);
    rd(ADDR_IMAGE_CAL, 8'h08);
    rd(ADDR_TEMP, 8'h47);
    wr(ADDR_IMAGE_CAL, 8'h80);
    tick(10);
    rd(ADDR_IMAGE_CAL, 8'h80);
    wr(ADDR_IMAGE_CAL, 8'hC1);
    rd(ADDR_IMAGE_CAL, 8'h81);
    chk_pin(PIN_SENSE, 8'h00);
    $display("test calibration done");
    // flags, sticky status and the interrupt
    radio.mode <= MODE_RX;
    tick(2);
    pulse(7'b1101011);
    rd(ADDR_FLAGS1, 8'hDF);
    rd(ADDR_IRQ_STAT, 8'hDF);
    chk_pin(PIN_IRQ, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h02);
    chk_pin(PIN_IRQ, 8'h20);
    wr(ADDR_FLAGS1, 8'h00);
    rd(ADDR_FLAGS1, 8'hDF);
    radio.signal_level_reading <= 8'h10;
    wr(ADDR_FLAGS1, 8'h0A);
    rd(ADDR_FLAGS1, 8'hD5);
    wr(ADDR_IRQ_STAT, 8'h02);
    chk_pin(PIN_IRQ, 8'h00);
    wr(ADDR_FLAGS1, 8'h02, 1'b1);
    rd(ADDR_FLAGS1, 8'hD7);
    chk_pin(PIN_IRQ, 8'h20);
    pulse(7'b0000100);
    rd(ADDR_FLAGS1, 8'hD2);
    radio.mode <= MODE_TX;
    tick(2);
    pulse(7'b0010000);
    rd(ADDR_FLAGS1, 8'h32);
    radio.pll_locked <= 1'b0;
    tick(2);
    rd(ADDR_FLAGS1, 8'h22);
    $display("test flags done");
    finish_test();
  end
endmodule // ssf_top_tb
